// ---- rtl/agt_defs.svh ----
`ifndef AGT_DEFS_SVH
`define AGT_DEFS_SVH

// clock and timing
`define AGT_CLK_HZ 100000000
`define AGT_DWELL_MS 200
`define AGT_TICK_NS 1000
`define AGT_CLK_NS 10
`define AGT_TICK_CYC (`AGT_TICK_NS / `AGT_CLK_NS)

// register indexes, byte address is index times four
`define AGT_IDX_CFG 14'h0000
`define AGT_IDX_TRAVEL 14'h0001
`define AGT_IDX_OVSPD 14'h0002
`define AGT_IDX_STAT 14'h0003
`define AGT_IDX_MODE 14'h2d50
`define AGT_IDX_PROG 14'h2d51
`define AGT_IDX_ABORT 14'h2d52
`define AGT_IDX_RESTORE 14'h2d53
`define AGT_IDX_FAULT 14'h2d54

// field values
`define AGT_MODE_IDLE 16'h0000
`define AGT_MODE_BASIC 16'h0001
`define AGT_MODE_HIGH 16'h0002
`define AGT_MODE_LOW 16'h0003
`define AGT_ABORT_KEY 16'h1EA5
`define AGT_RST_FACTORY 16'h0000
`define AGT_RST_PRIOR 16'h0001
`define AGT_PROG_DONE 16'h0064
`define AGT_TORQ_PCT 32'h0000_003C
`define AGT_PCT_FULL 32'h0000_0064

// fault codes
`define AGT_FLT_OK 16'h0000
`define AGT_FLT_CANCEL 16'hC000
`define AGT_FLT_SRVOFF 16'hC002
`define AGT_FLT_CTLMODE 16'hC003
`define AGT_FLT_STARTERR 16'hC006
`define AGT_FLT_ALARM 16'hC00A
`define AGT_FLT_DISABLED 16'hC00F
`define AGT_FLT_BASE 12'hC00

// reset values of own configuration
`define AGT_CFG_RST 16'h0000
`define AGT_TRAVEL_RST 16'h0000
`define AGT_OVSPD_RST 16'h0000

`endif

// ---- rtl/agt_pkg.sv ----
package agt_pkg;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_SERVO_UP = 2'b01,
        S_RUN = 2'b10
    } agt_state_t;

    typedef enum logic [1:0] {
        RK_START = 2'b00,
        RK_FACTORY = 2'b01,
        RK_PRIOR = 2'b10
    } agt_rkind_t;

    typedef struct packed {
        logic signed [31:0] pos;
        logic [15:0] speed;
        logic [15:0] torq_lim;
        logic dir;
    } agt_prof_t;
endpackage

// ---- rtl/agt_session.sv ----
`include "agt_defs.svh"

module agt_session
    import agt_pkg::*;
#(
    parameter logic [31:0] DWELL_CYCLES = 32'(`AGT_DWELL_MS * (`AGT_CLK_HZ / 1000))
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic awvalid,
    output logic awready,
    input wire logic [15:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [15:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic motor_at_rest,
    input wire logic servo_on_in,
    input wire logic tuning_enabled,
    input wire logic ctrl_mode_ok,
    input wire logic alarm,
    input wire logic ctrl_reset,
    input wire logic [7:0] eng_progress,
    input wire logic eng_done,
    input wire logic eng_fault,
    input wire logic [3:0] eng_fault_code,
    input wire logic signed [31:0] start_pos,
    input wire logic [15:0] rated_speed,
    input wire logic [15:0] rated_torque,
    input wire logic [15:0] torque_limit,
    output logic session_active,
    output logic [1:0] tune_mode,
    output logic servo_on_req,
    output logic ext_cmd_block,
    output logic int_cmd_active,
    output logic param_apply,
    output logic param_restore,
    output agt_rkind_t restore_kind,
    output logic nv_commit,
    output agt_prof_t prof
);
    agt_state_t state;
    logic aw_h, w_h, wr_go, wr_map, ar_map;
    logic [15:0] aw_a, wv, rd_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic [13:0] wr_idx, rd_idx;
    logic [15:0] cfg, travel, ovspd, progress, fault;
    logic start_req, abort_req, rst_req, start_ok, end_now, go_run;
    logic int_l;
    logic [15:0] st_code, end_code, spd_lim, half_spd;
    logic [31:0] t60w, dwell;
    logic [15:0] t60;
    logic signed [31:0] org, hi, lo, nup, ndn;
    logic [31:0] tick_cnt;
    logic tick;

    function automatic logic is_map(input logic [13:0] i);
        case (i)
            `AGT_IDX_CFG, `AGT_IDX_TRAVEL, `AGT_IDX_OVSPD, `AGT_IDX_STAT,
            `AGT_IDX_MODE, `AGT_IDX_PROG, `AGT_IDX_ABORT,
            `AGT_IDX_RESTORE, `AGT_IDX_FAULT: is_map = 1'b1;
            default: is_map = 1'b0;
        endcase
    endfunction

    // write address and data capture, either order
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_h <= 1'b0;
            w_h <= 1'b0;
            aw_a <= 16'h0000;
            w_d <= 32'h0000_0000;
            w_s <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_h <= 1'b1;
                aw_a <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_h <= 1'b1;
                w_d <= wdata;
                w_s <= wstrb;
                wready <= 1'b0;
            end
            if (wr_go) begin
                aw_h <= 1'b0;
                w_h <= 1'b0;
            end
            if (bvalid && bready) begin
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // write decode, low two byte lanes only
    assign wr_go = aw_h && w_h && !bvalid;
    assign wr_idx = aw_a[15:2];
    assign wr_map = is_map(wr_idx);
    assign wv = {w_s[1] ? w_d[15:8] : 8'h00, w_s[0] ? w_d[7:0] : 8'h00};

    // write response
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bvalid <= 1'b0;
            bresp <= 2'b00;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= wr_map ? 2'b00 : 2'b10;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read mux, write-only registers read zero
    assign rd_idx = araddr[15:2];
    assign ar_map = is_map(rd_idx);
    always_comb begin
        rd_v = 16'h0000;
        case (rd_idx)
            `AGT_IDX_CFG: rd_v = cfg;
            `AGT_IDX_TRAVEL: rd_v = travel;
            `AGT_IDX_OVSPD: rd_v = ovspd;
            `AGT_IDX_STAT: rd_v = {12'h000, ext_cmd_block, servo_on_req,
                                   int_cmd_active, session_active};
            `AGT_IDX_MODE: rd_v = {14'h0000, tune_mode};
            `AGT_IDX_PROG: rd_v = progress;
            `AGT_IDX_FAULT: rd_v = fault;
            default: rd_v = 16'h0000;
        endcase
    end

    // read channel
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'b00;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {16'h0000, rd_v};
            rresp <= ar_map ? 2'b00 : 2'b10;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // own configuration registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= `AGT_CFG_RST;
            travel <= `AGT_TRAVEL_RST;
            ovspd <= `AGT_OVSPD_RST;
        end else if (wr_go && state == S_IDLE) begin
            if (wr_idx == `AGT_IDX_CFG) cfg <= {15'h0000, wv[0]};
            if (wr_idx == `AGT_IDX_TRAVEL) travel <= {1'b0, wv[14:0]};
            if (wr_idx == `AGT_IDX_OVSPD) ovspd <= wv;
        end
    end

    // request decode from register writes
    assign start_req = wr_go && wr_idx == `AGT_IDX_MODE && state == S_IDLE
        && (wv == `AGT_MODE_BASIC || wv == `AGT_MODE_HIGH
        || wv == `AGT_MODE_LOW);
    assign abort_req = wr_go && wr_idx == `AGT_IDX_ABORT
        && wv == `AGT_ABORT_KEY && state != S_IDLE;
    assign rst_req = wr_go && wr_idx == `AGT_IDX_RESTORE && state == S_IDLE
        && (wv == `AGT_RST_FACTORY || wv == `AGT_RST_PRIOR);

    // start checks, first failing one wins
    always_comb begin
        st_code = `AGT_FLT_OK;
        if (!tuning_enabled) st_code = `AGT_FLT_DISABLED;
        else if (!ctrl_mode_ok) st_code = `AGT_FLT_CTLMODE;
        else if (cfg[0] && !motor_at_rest) st_code = `AGT_FLT_STARTERR;
    end
    assign start_ok = start_req && st_code == `AGT_FLT_OK;

    // end of session and its code, abort first
    always_comb begin
        end_now = 1'b0;
        end_code = `AGT_FLT_OK;
        if (state != S_IDLE) begin
            if (abort_req) begin
                end_now = 1'b1;
                end_code = `AGT_FLT_CANCEL;
            end else if (alarm) begin
                end_now = 1'b1;
                end_code = `AGT_FLT_ALARM;
            end else if (state == S_RUN && !servo_on_in) begin
                end_now = 1'b1;
                end_code = `AGT_FLT_SRVOFF;
            end else if (state == S_RUN && eng_fault) begin
                end_now = 1'b1;
                end_code = {`AGT_FLT_BASE, eng_fault_code};
            end else if (state == S_RUN && eng_done) begin
                end_now = 1'b1;
                end_code = `AGT_FLT_OK;
            end
        end
    end
    assign go_run = (start_ok && !(cfg[0] && !servo_on_in))
        || (state == S_SERVO_UP && servo_on_in && !end_now);

    // session sequencer, mode, progress and fault
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= S_IDLE;
            tune_mode <= 2'b00;
            progress <= 16'h0000;
            fault <= `AGT_FLT_OK;
            session_active <= 1'b0;
            int_l <= 1'b0;
        end else if (end_now) begin
            state <= S_IDLE;
            tune_mode <= 2'b00;
            progress <= `AGT_PROG_DONE;
            fault <= end_code;
            session_active <= 1'b0;
        end else if (start_req && !start_ok) begin
            progress <= `AGT_PROG_DONE;
            fault <= st_code;
        end else if (start_ok) begin
            state <= go_run ? S_RUN : S_SERVO_UP;
            tune_mode <= wv[1:0];
            progress <= 16'h0000;
            fault <= `AGT_FLT_OK;
            session_active <= 1'b1;
            int_l <= cfg[0];
        end else if (state == S_SERVO_UP && go_run) begin
            state <= S_RUN;
        end else if (state == S_RUN) begin
            progress <= (eng_progress < 8'h64) ? {8'h00, eng_progress}
                                               : 16'h0063;
        end
    end

    // parameter apply, restore and commit pulses
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            param_apply <= 1'b0;
            param_restore <= 1'b0;
            restore_kind <= RK_START;
            nv_commit <= 1'b0;
        end else begin
            param_apply <= end_now && end_code == `AGT_FLT_OK;
            param_restore <= rst_req || (end_now && abort_req);
            nv_commit <= rst_req;
            if (end_now && abort_req) begin
                restore_kind <= RK_START;
            end else if (rst_req) begin
                restore_kind <= wv[0] ? RK_PRIOR : RK_FACTORY;
            end
        end
    end

    // servo-on request and external command gate
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            servo_on_req <= 1'b0;
            ext_cmd_block <= 1'b0;
            int_cmd_active <= 1'b0;
        end else begin
            if (start_ok && cfg[0]) begin
                servo_on_req <= 1'b1;
                int_cmd_active <= 1'b1;
            end else if (end_now && int_l) begin
                servo_on_req <= 1'b0;
                int_cmd_active <= 1'b0;
            end
            if ((start_ok && cfg[0]) || (end_now && int_l)) begin
                ext_cmd_block <= 1'b1;
            end else if (ctrl_reset && state == S_IDLE) begin
                ext_cmd_block <= 1'b0;
            end
        end
    end

    // profile limits
    assign half_spd = rated_speed >> 1;
    assign spd_lim = (ovspd < half_spd) ? ovspd : half_spd;
    assign t60w = ({16'h0000, rated_torque} * `AGT_TORQ_PCT) / `AGT_PCT_FULL;
    assign t60 = t60w[15:0];
    assign hi = org + $signed({16'h0000, travel});
    assign lo = org - $signed({16'h0000, travel});
    assign nup = prof.pos + $signed({16'h0000, prof.speed});
    assign ndn = prof.pos - $signed({16'h0000, prof.speed});

    // motion step enable divider
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (tick_cnt == 32'(`AGT_TICK_CYC - 1)) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            tick <= 1'b0;
        end
    end

    // reciprocating profile generator
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prof <= '0;
            org <= 32'sh0000_0000;
            dwell <= 32'h0000_0000;
        end else if (go_run) begin
            prof.pos <= start_pos;
            org <= start_pos;
            prof.dir <= 1'b1;
            prof.speed <= spd_lim;
            prof.torq_lim <= (t60 < torque_limit) ? t60 : torque_limit;
            dwell <= 32'h0000_0000;
        end else if (state == S_RUN && int_l && !end_now) begin
            if (dwell != 32'h0000_0000) begin
                dwell <= dwell - 32'h0000_0001;
            end else if (tick) begin
                if (prof.dir) begin
                    if (nup >= hi || nup < prof.pos) begin
                        prof.pos <= hi;
                        prof.dir <= 1'b0;
                        dwell <= DWELL_CYCLES;
                    end else begin
                        prof.pos <= nup;
                    end
                end else begin
                    if (ndn <= lo || ndn > prof.pos) begin
                        prof.pos <= lo;
                        prof.dir <= 1'b1;
                        dwell <= DWELL_CYCLES;
                    end else begin
                        prof.pos <= ndn;
                    end
                end
            end
        end else if (state == S_IDLE) begin
            prof.speed <= 16'h0000;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    property p_start_mode;
        $rose(session_active) |-> tune_mode != 2'b00 && fault == `AGT_FLT_OK;
    endproperty
    a_start_mode: assert property (p_start_mode)
        else $error("session started without a response mode");

    property p_mode_clear;
        $fell(session_active) |-> tune_mode == 2'b00;
    endproperty
    a_mode_clear: assert property (p_mode_clear)
        else $error("mode not cleared at session end");

    property p_prog_done;
        $fell(session_active) |-> progress == `AGT_PROG_DONE;
    endproperty
    a_prog_done: assert property (p_prog_done)
        else $error("progress not 100 at session end");

    property p_prog_run;
        session_active && state == S_RUN |=> progress != `AGT_PROG_DONE
            || !session_active;
    endproperty
    a_prog_run: assert property (p_prog_run)
        else $error("progress shows done while running");

    property p_abort;
        abort_req |=> !session_active && fault == `AGT_FLT_CANCEL
            && param_restore && restore_kind == RK_START;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort did not cancel and restore");

    property p_commit;
        param_restore && restore_kind != RK_START |-> nv_commit;
    endproperty
    a_commit: assert property (p_commit)
        else $error("restore without non-volatile commit");

    property p_apply_ok;
        param_apply |-> fault == `AGT_FLT_OK && !session_active;
    endproperty
    a_apply_ok: assert property (p_apply_ok)
        else $error("parameters applied on failed session");

    property p_rest_start;
        start_req && cfg[0] && !motor_at_rest && tuning_enabled && ctrl_mode_ok
            |=> fault == `AGT_FLT_STARTERR && !session_active;
    endproperty
    a_rest_start: assert property (p_rest_start)
        else $error("internal start while rotating not refused");

    property p_servo_up;
        state == S_SERVO_UP |-> servo_on_req && int_cmd_active;
    endproperty
    a_servo_up: assert property (p_servo_up)
        else $error("no servo-on request while waiting for servo");

    property p_range;
        state == S_RUN && int_l |-> prof.pos <= hi && prof.pos >= lo;
    endproperty
    a_range: assert property (p_range)
        else $error("profile left the permitted travel range");

    property p_speed;
        state == S_RUN && int_l |-> prof.speed <= ovspd
            && prof.speed <= half_spd;
    endproperty
    a_speed: assert property (p_speed)
        else $error("profile speed above its limits");

    property p_int_end;
        end_now && int_l |=> !servo_on_req && ext_cmd_block;
    endproperty
    a_int_end: assert property (p_int_end)
        else $error("internal session end left servo on or gate open");
endmodule

// ---- tb/agt_drive_model.sv ----
module agt_drive_model (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic servo_on_req,
    input wire logic session_active,
    input wire logic ext_servo,
    input wire logic finish_en,
    output logic servo_on_in,
    output logic [7:0] eng_progress,
    output logic eng_done
);
    timeunit 1ns;
    timeprecision 1ps;
    // drive turns servo on one cycle after either request
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            servo_on_in <= 1'b0;
        end else begin
            servo_on_in <= servo_on_req | ext_servo;
        end
    end
    // engine ramps progress while a session is active
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            eng_progress <= 8'h00;
        end else if (!session_active) begin
            eng_progress <= 8'h00;
        end else if (eng_progress < 8'h64) begin
            eng_progress <= eng_progress + 8'h01;
        end
    end
    assign eng_done = session_active && finish_en && eng_progress == 8'h64;
endmodule

// ---- tb/testbench.sv ----
module testbench
    import agt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, motor_at_rest, servo_on_in, tuning_enabled;
    logic ctrl_mode_ok, alarm, ctrl_reset, eng_done, eng_fault, session_active, servo_on_req;
    logic ext_cmd_block, int_cmd_active, param_apply, param_restore, nv_commit, ext_servo, finish_en;
    logic [15:0] awaddr, araddr, rated_speed, rated_torque, torque_limit, rd;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, eng_fault_code;
    logic [1:0] bresp, rresp, tune_mode, rs;
    logic [7:0] eng_progress;
    logic signed [31:0] start_pos;
    agt_rkind_t restore_kind;
    agt_prof_t prof;
    int bad_count, checked, cyc, n_apply, e;
    int rk_q[$];
    agt_session #(.DWELL_CYCLES(32'h0000_0014)) u_agt_session (
        .clock, .arst_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
        .rresp, .motor_at_rest, .servo_on_in, .tuning_enabled, .ctrl_mode_ok, .alarm,
        .ctrl_reset, .eng_progress, .eng_done, .eng_fault, .eng_fault_code, .start_pos,
        .rated_speed, .rated_torque, .torque_limit, .session_active, .tune_mode,
        .servo_on_req, .ext_cmd_block, .int_cmd_active, .param_apply, .param_restore,
        .restore_kind, .nv_commit, .prof
    );
    agt_drive_model u_agt_drive_model (
        .clock, .arst_n, .servo_on_req, .session_active, .ext_servo, .finish_en,
        .servo_on_in, .eng_progress, .eng_done
    );
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // axi-lite write, both channels offered together
    task automatic wr(input logic [13:0] idx, input logic [15:0] d);
        logic a;
        logic w;
        a = 1'b0;
        w = 1'b0;
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0000, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(a && w)) begin
            @(posedge clock);
            if (!a && awready === 1'b1) begin
                a = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clock);
        rs = bresp;
        bready <= 1'b0;
        // one edge passes so a next call never re-raises bready at once
        @(posedge clock);
    endtask
    // axi-lite read of the low half word
    task automatic rd_reg(input logic [13:0] idx);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clock);
        rready <= 1'b0;
        rd = rdata[15:0];
        rs = rresp;
        // one edge passes so a next call never re-raises rready at once
        @(posedge clock);
    endtask
    // poll the mode register until the session has ended
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            rd_reg(14'h2d50);
            n++;
        end while (rd !== 16'h0000 && n < 60);
        chk_val(rd, 16'h0000);
    endtask
    // one session ended by done, abort, alarm, servo-off or engine fault
    task automatic sess(input int mode, input int how, input logic [3:0] nib);
        logic [15:0] ef;
        ef = (how == 0) ? 16'h0000 : (how == 1) ? 16'hC000 : (how == 2) ? 16'hC00A :
            (how == 3) ? 16'hC002 : {12'hC00, nib};
        wr(14'h2d50, 16'(mode));
        rd_reg(14'h2d50);
        chk_val(rd, 16'(mode));
        rd_reg(14'h2d51);
        chk_flag(rd < 16'h0064, 1'b1);
        case (how)
            0: finish_en <= 1'b1;
            1: begin
                wr(14'h2d52, 16'h1EA4);
                chk_flag(session_active, 1'b1);
                rk_q.push_back(0);
                wr(14'h2d52, 16'h1EA5);
            end
            2: alarm <= 1'b1;
            3: ext_servo <= 1'b0;
            default: begin
                eng_fault_code <= nib;
                eng_fault <= 1'b1;
            end
        endcase
        wait_idle();
        alarm <= 1'b0;
        ext_servo <= 1'b1;
        eng_fault <= 1'b0;
        finish_en <= 1'b0;
        rd_reg(14'h2d51);
        chk_val(rd, 16'h0064);
        rd_reg(14'h2d54);
        chk_val(rd, ef);
    endtask
    // restore pulses against the queue, apply pulses counted, motion range
    always @(posedge clock) begin
        if (param_apply === 1'b1) n_apply++;
        if (param_restore === 1'b1) begin
            e = (rk_q.size() > 0) ? rk_q.pop_front() : 3;
            chk_val(16'(restore_kind), 16'(e));
            chk_flag(nv_commit, e != 0);
        end else if (nv_commit === 1'b1) chk_flag(1'b0, 1'b1);
        if (int_cmd_active === 1'b1 && prof.speed != 16'h0000)
            chk_flag(prof.pos >= start_pos - 32 && prof.pos <= start_pos + 32, 1'b1);
        cyc++;
        if (cyc >= 20000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready, alarm, ctrl_reset} = '0;
        {eng_fault, finish_en, tuning_enabled, awaddr, araddr, wdata} = '0;
        {wstrb, eng_fault_code, start_pos} = '0;
        {motor_at_rest, ctrl_mode_ok, ext_servo} = 3'b111;
        rated_speed = 16'h0BB8;
        rated_torque = 16'h00C8;
        torque_limit = 16'h0064;
        void'($urandom(82));
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rd_reg(14'h0100);
        chk_val(16'(rs), 16'h0002);
        wr(14'h0100, 16'h0001);
        chk_val(16'(rs), 16'h0002);
        wr(14'h2d50, 16'h0001);
        chk_val(16'(rs), 16'h0000);
        rd_reg(14'h2d54);
        chk_val(rd, 16'hC00F);
        rd_reg(14'h2d51);
        chk_val(rd, 16'h0064);
        tuning_enabled <= 1'b1;
        for (int m = 1; m <= 3; m++) sess(m, 0, 4'h0);
        sess(1, 1, 4'h0);
        sess(2, 2, 4'h0);
        sess(3, 3, 4'h0);
        sess(2, 4, 4'h1);
        for (int k = 0; k < 3; k++) sess(k + 1, 4, 4'($urandom_range(9, 4)));
        chk_val(16'(n_apply), 16'h0003);
        rk_q.push_back(1);
        wr(14'h2d53, 16'h0000);
        rk_q.push_back(2);
        wr(14'h2d53, 16'h0001);
        wr(14'h2d53, 16'h0005);
        wr(14'h0000, 16'h0001);
        wr(14'h0001, 16'h0020);
        wr(14'h0002, 16'h03E8);
        motor_at_rest <= 1'b0;
        wr(14'h2d50, 16'h0001);
        rd_reg(14'h2d54);
        chk_val(rd, 16'hC006);
        motor_at_rest <= 1'b1;
        ext_servo <= 1'b0;
        start_pos <= 32'($urandom_range(1000000));
        wr(14'h2d50, 16'h0002);
        chk_flag(servo_on_req, 1'b1);
        repeat (10) @(posedge clock);
        chk_flag(int_cmd_active, 1'b1);
        chk_val(prof.speed, 16'h03E8);
        chk_val(prof.torq_lim, 16'h0064);
        finish_en <= 1'b1;
        wait_idle();
        finish_en <= 1'b0;
        chk_flag(servo_on_req, 1'b0);
        chk_flag(ext_cmd_block, 1'b1);
        ctrl_reset <= 1'b1;
        @(posedge clock);
        ctrl_reset <= 1'b0;
        repeat (2) @(posedge clock);
        chk_flag(ext_cmd_block, 1'b0);
        chk_val(16'(rk_q.size()), 16'h0000);
        complete_run();
    end
endmodule
